// ### hdl/amc_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "amc_cfg.svh"

module amc_top (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Access request
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [1:0] req_bank,
    input wire logic [`AMC_BA_W-1:0] req_ba,
    input wire logic [`AMC_ADDR_W-1:0] req_addr,
    output logic req_ready,
    output logic access_done,
    output logic busy,
    // Configuration, each timing code is clocks minus one, the timeout limit is wait blocks minus one
    input wire logic cfg_select_strobe,
    input wire logic extended_wait_enable,
    input wire logic [1:0] bus_turnaround,
    input wire logic [3:0] read_setup,
    input wire logic [5:0] read_strobe,
    input wire logic [2:0] read_hold,
    input wire logic [3:0] write_setup,
    input wire logic [5:0] write_strobe,
    input wire logic [2:0] write_hold,
    input wire logic [7:0] wait_timeout_limit,
    // Status
    output logic [`AMC_EWC_W-1:0] external_wait_count,
    output logic wait_timeout,
    // Memory pins
    output logic [`AMC_CS_W-1:0] chip_select_n,
    output logic output_enable_n,
    output logic write_enable_n,
    input wire logic wait_input_n,
    output logic [`AMC_BA_W-1:0] bank_select_lines,
    output logic [`AMC_ADDR_W-1:0] memory_address_lines
);

    logic rst_meta_reg;
    logic rst_n;
    amc_pkg::amc_state_e state_reg;
    amc_pkg::amc_state_e state_next;
    logic wr_reg;
    logic [1:0] bank_reg;
    logic [`AMC_EWC_W-1:0] ewc_reg;
    logic [`AMC_EWC_W-1:0] ewc_next;
    logic cnt_load;
    logic [`AMC_CNT_W-1:0] cnt_val;
    logic [`AMC_CNT_W-1:0] cnt;
    logic cnt_last;
    logic tmo_next;
    logic done_next;
    logic wr_sel;
    logic [1:0] bank_sel;
    logic [`AMC_CNT_W-1:0] setup_len;
    logic [`AMC_CNT_W-1:0] strobe_len;
    logic [`AMC_CNT_W-1:0] hold_len;
    logic [`AMC_CNT_W-1:0] turn_len;
    logic [`AMC_EWC_W-1:0] limit;
    logic cs_on;
    logic strobe_on;
    logic [`AMC_CS_W-1:0] cs_reg;
    logic oe_reg;
    logic we_reg;
    logic [`AMC_BA_W-1:0] ba_reg;
    logic [`AMC_ADDR_W-1:0] addr_reg;
    logic ready_reg;
    logic done_reg;
    logic busy_reg;
    logic tmo_reg;
    logic [`AMC_EWC_W-1:0] ewc_out_reg;
    default clocking amc_cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // Reset release through two flops
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    // Phase lengths from the programmed codes
    assign wr_sel = (state_reg == amc_pkg::AMC_IDLE) ? req_write : wr_reg;
    assign bank_sel = (state_reg == amc_pkg::AMC_IDLE) ? req_bank : bank_reg;
    assign setup_len = wr_sel ? amc_pkg::amc_len7({2'h0, write_setup})
        : amc_pkg::amc_len7({2'h0, read_setup});
    assign strobe_len = wr_sel ? amc_pkg::amc_len7(write_strobe)
                               : amc_pkg::amc_len7(read_strobe);
    assign hold_len = wr_sel ? amc_pkg::amc_len7({3'h0, write_hold})
                             : amc_pkg::amc_len7({3'h0, read_hold});
    assign turn_len = amc_pkg::amc_len7({4'h0, bus_turnaround});
    assign limit = amc_pkg::amc_len9(wait_timeout_limit);

    amc_phase_cnt u_cnt (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .load(cnt_load),
        .load_val(cnt_val),
        .count(cnt),
        .last(cnt_last)
    );

    always_comb begin
        state_next = state_reg;
        cnt_load = 1'b0;
        cnt_val = 7'h01;
        ewc_next = ewc_reg;
        tmo_next = 1'b0;
        done_next = 1'b0;
        case (state_reg)
            amc_pkg::AMC_IDLE: begin
                if (req_valid) begin
                    state_next = amc_pkg::AMC_SETUP;
                    cnt_load = 1'b1;
                    cnt_val = setup_len;
                    ewc_next = `AMC_EWC_RST;
                end
            end
            amc_pkg::AMC_SETUP: begin
                if (cnt_last) begin
                    state_next = amc_pkg::AMC_STROBE;
                    cnt_load = 1'b1;
                    cnt_val = strobe_len;
                end
            end
            amc_pkg::AMC_STROBE: begin
                if (cnt_last && extended_wait_enable && !wait_input_n) begin
                    state_next = amc_pkg::AMC_EXTW;
                    cnt_load = 1'b1;
                    cnt_val = `AMC_WAIT_BLOCK;
                    ewc_next = 9'h001;
                end else if (cnt_last) begin
                    state_next = amc_pkg::AMC_HOLD;
                    cnt_load = 1'b1;
                    cnt_val = hold_len;
                end
            end
            amc_pkg::AMC_EXTW: begin
                if (cnt_last && !wait_input_n && ewc_reg < limit) begin
                    cnt_load = 1'b1;
                    cnt_val = `AMC_WAIT_BLOCK;
                    ewc_next = ewc_reg + 9'h001;
                end else if (cnt_last) begin
                    state_next = amc_pkg::AMC_HOLD;
                    cnt_load = 1'b1;
                    cnt_val = hold_len;
                    tmo_next = !wait_input_n;
                end else if (wait_input_n && cnt >= `AMC_RELEASE_MIN) begin
                    cnt_load = 1'b1;
                    cnt_val = `AMC_RELEASE_DELAY;
                end
            end
            amc_pkg::AMC_HOLD: begin
                if (cnt_last) begin
                    state_next = amc_pkg::AMC_TURN;
                    cnt_load = 1'b1;
                    cnt_val = turn_len;
                    done_next = 1'b1;
                end
            end
            amc_pkg::AMC_TURN: begin
                if (cnt_last) begin
                    state_next = amc_pkg::AMC_IDLE;
                end
            end
            default: begin
                state_next = amc_pkg::AMC_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= amc_pkg::AMC_IDLE;
            ewc_reg <= `AMC_EWC_RST;
        end else begin
            state_reg <= state_next;
            ewc_reg <= ewc_next;
        end
    end

    // Access attributes latched when the request is taken
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_reg <= 1'b0;
            bank_reg <= 2'h3;
            ba_reg <= `AMC_BA_RST;
            addr_reg <= `AMC_ADDR_RST;
        end else if (state_reg == amc_pkg::AMC_IDLE && req_valid) begin
            wr_reg <= req_write;
            bank_reg <= req_bank;
            ba_reg <= req_ba;
            addr_reg <= req_addr;
        end
    end

    // Pin levels follow the next phase so they change on its first edge
    assign strobe_on = (state_next == amc_pkg::AMC_STROBE) ||
                       (state_next == amc_pkg::AMC_EXTW);
    assign cs_on = cfg_select_strobe ? strobe_on
                 : (strobe_on || state_next == amc_pkg::AMC_SETUP ||
                    state_next == amc_pkg::AMC_HOLD);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_reg <= `AMC_CS_IDLE;
            oe_reg <= 1'b1;
            we_reg <= 1'b1;
        end else begin
            cs_reg <= cs_on ? amc_pkg::amc_cs_dec(bank_sel)
                            : `AMC_CS_IDLE;
            oe_reg <= !(strobe_on && !wr_sel);
            we_reg <= !(strobe_on && wr_sel);
        end
    end

    // Status
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ready_reg <= 1'b0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            tmo_reg <= 1'b0;
            ewc_out_reg <= `AMC_EWC_RST;
        end else begin
            ready_reg <= (state_next == amc_pkg::AMC_IDLE);
            busy_reg <= (state_next != amc_pkg::AMC_IDLE);
            done_reg <= done_next;
            tmo_reg <= tmo_next;
            ewc_out_reg <= ewc_next;
        end
    end

    assign req_ready = ready_reg;
    assign access_done = done_reg;
    assign busy = busy_reg;
    assign wait_timeout = tmo_reg;
    assign external_wait_count = ewc_out_reg;
    assign chip_select_n = cs_reg;
    assign output_enable_n = oe_reg;
    assign write_enable_n = we_reg;
    assign bank_select_lines = ba_reg;
    assign memory_address_lines = addr_reg;

    // Cycles spent in the current phase, for the checks below
    logic [7:0] ph_age_reg;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ph_age_reg <= 8'h00;
        end else if (state_next != state_reg) begin
            ph_age_reg <= 8'h00;
        end else if (ph_age_reg != 8'hff) begin
            ph_age_reg <= ph_age_reg + 8'h01;
        end
    end
    sequence s_leave_setup;
        state_reg == amc_pkg::AMC_SETUP && state_next != amc_pkg::AMC_SETUP;
    endsequence
    sequence s_release;
        state_reg == amc_pkg::AMC_EXTW && wait_input_n && !wr_reg &&
        cnt >= `AMC_RELEASE_MIN;
    endsequence

    AST_SETUP_LEN: assert property (
        s_leave_setup |-> {1'b0, setup_len} == ph_age_reg + 8'h01)
        else $error("setup phase length wrong");

    AST_STROBE_LEN: assert property (
        state_reg == amc_pkg::AMC_STROBE && state_next != amc_pkg::AMC_STROBE
        |-> {1'b0, strobe_len} == ph_age_reg + 8'h01)
        else $error("strobe phase length wrong");

    AST_HOLD_LEN: assert property (
        state_reg == amc_pkg::AMC_HOLD && state_next == amc_pkg::AMC_TURN
        |-> {1'b0, hold_len} == ph_age_reg + 8'h01 ##1 access_done)
        else $error("hold phase length or done pulse wrong");

    AST_TURN_LEN: assert property (
        state_reg == amc_pkg::AMC_TURN && state_next == amc_pkg::AMC_IDLE
        |-> {1'b0, turn_len} == ph_age_reg + 8'h01)
        else $error("turnaround length wrong");

    AST_SS_CS: assert property (
        cfg_select_strobe && $stable(cfg_select_strobe) && bank_reg != 2'h3 &&
        state_reg != amc_pkg::AMC_IDLE
        |-> (chip_select_n != `AMC_CS_IDLE) ==
            (!output_enable_n || !write_enable_n))
        else $error("select does not follow strobe");

    AST_SETUP_CS: assert property (
        !cfg_select_strobe && state_reg == amc_pkg::AMC_SETUP &&
        bank_reg != 2'h3 |-> chip_select_n != `AMC_CS_IDLE &&
        output_enable_n && write_enable_n)
        else $error("select not leading strobe");

    AST_IDLE_HIGH: assert property (
        state_reg == amc_pkg::AMC_IDLE |-> chip_select_n == `AMC_CS_IDLE &&
        output_enable_n && write_enable_n)
        else $error("pins active while idle");

    AST_RELEASE: assert property (
        s_release |=> !output_enable_n [*4] ##1 output_enable_n)
        else $error("release to strobe end not four clocks");

    AST_EWC_STEP: assert property (
        state_reg == amc_pkg::AMC_EXTW && cnt_last && !wait_input_n &&
        ewc_reg < limit |=> ewc_reg == $past(ewc_reg) + 9'h001 &&
        cnt == `AMC_WAIT_BLOCK)
        else $error("wait block not counted");

    AST_TIMEOUT: assert property (
        state_reg == amc_pkg::AMC_EXTW && cnt_last && !wait_input_n &&
        ewc_reg == limit |=> state_reg == amc_pkg::AMC_HOLD && wait_timeout)
        else $error("timeout did not end the wait");

endmodule

`default_nettype wire

// ### hdl/amc_cfg.svh
`ifndef AMC_CFG_SVH
`define AMC_CFG_SVH

// Interface clock
`define AMC_CLK_PERIOD_NS 100

// Pin and field widths
`define AMC_CS_W 3
`define AMC_BA_W 2
`define AMC_ADDR_W 22
`define AMC_CNT_W 7
`define AMC_EWC_W 9

// Extended wait timing, in interface clocks
`define AMC_WAIT_BLOCK 7'h10
`define AMC_RELEASE_DELAY 7'h04
`define AMC_RELEASE_MIN 7'h05

// Reset and idle values
`define AMC_CS_IDLE 3'h7
`define AMC_ADDR_RST 22'h000000
`define AMC_BA_RST 2'h0
`define AMC_EWC_RST 9'h000

`endif

// ### hdl/amc_pkg.sv
package amc_pkg;

    typedef enum logic [2:0] {
        AMC_IDLE = 3'h0,
        AMC_SETUP = 3'h1,
        AMC_STROBE = 3'h3,
        AMC_HOLD = 3'h2,
        AMC_TURN = 3'h6,
        AMC_EXTW = 3'h7
    } amc_state_e;

    // Programmed code n stands for n + 1 clocks
    function automatic logic [6:0] amc_len7(input logic [5:0] code);
        amc_len7 = {1'b0, code} + 7'h01;
    endfunction

    function automatic logic [8:0] amc_len9(input logic [7:0] code);
        amc_len9 = {1'b0, code} + 9'h001;
    endfunction

    // One-hot active-low select; code 3 selects nothing
    function automatic logic [2:0] amc_cs_dec(input logic [1:0] bank);
        if (bank == 2'h0) begin
            amc_cs_dec = 3'h6;
        end else if (bank == 2'h1) begin
            amc_cs_dec = 3'h5;
        end else if (bank == 2'h2) begin
            amc_cs_dec = 3'h3;
        end else begin
            amc_cs_dec = 3'h7;
        end
    endfunction

endpackage

// ### hdl/amc_phase_cnt.sv
`timescale 1ns/10ps
`default_nettype none
`include "amc_cfg.svh"

module amc_phase_cnt (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Load
    input wire logic load,
    input wire logic [`AMC_CNT_W-1:0] load_val,
    // State
    output logic [`AMC_CNT_W-1:0] count,
    output logic last
);

    logic [`AMC_CNT_W-1:0] count_reg;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= 7'h00;
        end else if (load) begin
            count_reg <= load_val;
        end else if (count_reg != 7'h00) begin
            count_reg <= count_reg - 7'h01;
        end
    end

    assign count = count_reg;
    assign last = (count_reg == 7'h01);

endmodule

`default_nettype wire

// ### tb/amc_mem_model.sv
`timescale 1ns/10ps
`default_nettype none

module amc_mem_model (
    // Clock
    input wire logic ref_clk,
    // Memory pins
    input wire logic [2:0] chip_select_n,
    input wire logic output_enable_n,
    input wire logic write_enable_n,
    output logic wait_input_n,
    // Clocks of wait counted from strobe start
    input wire logic [15:0] hold_len
);
    int j;

    initial begin
        wait_input_n = 1'b1;
        j = 0;
    end

    // Wait is raised with the strobe, well ahead of the hold phase
    always @(posedge ref_clk) begin
        #1;
        if ((output_enable_n && write_enable_n) || chip_select_n == 3'h7) begin
            j = 0;
            wait_input_n = 1'b1;
        end else begin
            wait_input_n = (j >= hold_len);
            j = j + 1;
        end
    end
endmodule

`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    logic ref_clk, nrst, req_valid, req_write, sel_strb, xw_en;
    logic [1:0] req_bank, req_ba, turn;
    logic [21:0] req_addr;
    logic [3:0] rd_set, wr_set;
    logic [5:0] rd_str, wr_str;
    logic [2:0] rd_hld, wr_hld;
    logic [7:0] tmo_lim;
    logic req_ready, access_done, busy, tmo, oe_n, we_n, wait_n;
    logic [8:0] wcount;
    logic [2:0] cs_n;
    logic [1:0] ba_o;
    logic [21:0] addr_o;
    logic [15:0] hold_len;
    int fail_count, total_checks, cycles, i;
    int exp_q[$];

    amc_top amc_top_i (.ref_clk(ref_clk), .nrst(nrst),
        .req_valid(req_valid), .req_write(req_write), .req_bank(req_bank),
        .req_ba(req_ba), .req_addr(req_addr), .req_ready(req_ready),
        .access_done(access_done), .busy(busy),
        .cfg_select_strobe(sel_strb), .extended_wait_enable(xw_en),
        .bus_turnaround(turn), .read_setup(rd_set), .read_strobe(rd_str),
        .read_hold(rd_hld), .write_setup(wr_set), .write_strobe(wr_str),
        .write_hold(wr_hld), .wait_timeout_limit(tmo_lim),
        .external_wait_count(wcount), .wait_timeout(tmo),
        .chip_select_n(cs_n), .output_enable_n(oe_n), .write_enable_n(we_n),
        .wait_input_n(wait_n), .bank_select_lines(ba_o),
        .memory_address_lines(addr_o));

    amc_mem_model amc_mem_model_i (.ref_clk(ref_clk), .chip_select_n(cs_n),
        .output_enable_n(oe_n), .write_enable_n(we_n),
        .wait_input_n(wait_n), .hold_len(hold_len));

    always #50 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 40000) begin
            fail_count++;
            $display("[FAIL] %0t run too long", $time);
            print_verdict();
        end
    end

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk_pin(input string w, input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s got %0h exp %0h", $time, w, got, exp);
        end
    endtask

    task automatic chk_cnt(input string w, input int got, exp);
        total_checks++;
        if (got != exp) begin
            fail_count++;
            $display("[FAIL] %0t %s got %0d exp %0d", $time, w, got, exp);
        end
    endtask

    task automatic step;
        @(posedge ref_clk);
        #2;
    endtask

    task automatic cfg(input logic [27:0] a, input logic [7:0] b);
        {rd_set, rd_str, rd_hld, wr_set, wr_str, wr_hld, turn} = a;
        tmo_lim = b;
    endtask

    // Mode 0 no wait, 1 wait held on, 2 wait let go inside first block
    task automatic access(input logic wr, input logic [1:0] bank,
                          input int mode);
        int s, t, h, n_set, n_str, n_hold, n_cs, k, rel_k, up_k, bad;
        int e_str, e_wc;
        logic to_seen, strb;
        logic [2:0] e_cs;
        logic [1:0] ba;
        logic [21:0] ad;
        ba = 2'($urandom);
        ad = 22'($urandom);
        s = (wr ? wr_set : rd_set) + 1;
        t = (wr ? wr_str : rd_str) + 1;
        h = (wr ? wr_hld : rd_hld) + 1;
        e_cs = (bank == 2'h3) ? 3'h7 : ~(3'h1 << bank);
        hold_len = (mode == 0) ? 16'h0 : (mode == 1) ? 16'hffff : 16'(t + 4);
        e_str = t;
        e_wc = 0;
        if (xw_en && mode == 1) begin
            e_str = t + 16 * (tmo_lim + 1);
            e_wc = tmo_lim + 1;
        end else if (xw_en && mode == 2) begin
            e_str = t + 9;
            e_wc = 1;
        end
        exp_q.push_back(s + e_str + h);
        k = 0;
        while (req_ready !== 1'b1 && k < 100) begin
            step();
            k++;
        end
        // Raise the request only once ready shows, so it is taken at once
        {req_write, req_bank, req_ba} = {wr, bank, ba};
        req_addr = ad;
        req_valid = 1'b1;
        step();
        req_valid = 1'b0;
        chk_pin("busy", busy, 1);
        {n_set, n_str, n_hold, n_cs, k, bad, to_seen} = '0;
        rel_k = -1;
        up_k = -1;
        while (access_done !== 1'b1 && k < 5000) begin
            strb = wr ? !we_n : !oe_n;
            if ((wr ? !oe_n : !we_n) || {ba_o, addr_o} !== {ba, ad}) bad++;
            if (cs_n !== e_cs && cs_n !== 3'h7) bad++;
            if (strb) begin
                n_str++;
                if (cs_n !== 3'h7) n_cs++;
            end else if (cs_n !== 3'h7) begin
                if (n_str == 0) n_set++;
                else n_hold++;
            end
            if (n_str > 0 && wait_n === 1'b1 && rel_k < 0) rel_k = k;
            if (n_str > 0 && !strb && up_k < 0) up_k = k;
            to_seen |= tmo;
            step();
            k++;
        end
        to_seen |= tmo;
        chk_cnt("cycle", k, exp_q.pop_front());
        chk_cnt("strobe", n_str, e_str);
        chk_cnt("setup", n_set, (sel_strb || bank == 3) ? 0 : s);
        chk_cnt("hold", n_hold, (sel_strb || bank == 3) ? 0 : h);
        chk_cnt("cs strobe", n_cs, (bank == 3) ? 0 : e_str);
        chk_cnt("pins", bad, 0);
        chk_pin("waits", wcount, e_wc);
        chk_pin("timeout", to_seen, xw_en && mode == 1);
        if (xw_en && mode == 2) chk_cnt("release", up_k - rel_k, 5);
        bad = 0;
        k = 0;
        while (req_ready !== 1'b1 && k < 10) begin
            if ({cs_n, oe_n, we_n} !== 5'h1f) bad++;
            step();
            k++;
        end
        chk_cnt("turn", k, turn + 1);
        chk_cnt("idle", bad, 0);
    endtask

    initial begin
        {ref_clk, nrst, req_valid, req_write, sel_strb, xw_en} = '0;
        {req_bank, req_ba, req_addr, hold_len} = '0;
        cfg(28'h0, 8'h00);
        void'($urandom(11335));
        repeat (20) @(posedge ref_clk);
        #2;
        chk_pin("reset pins", {cs_n, oe_n, we_n, req_ready}, 6'h3e);
        nrst = 1'b1;
        for (i = 0; i < 16; i++) begin
            cfg(28'($urandom), 8'($urandom));
            {sel_strb, xw_en} = 2'($urandom);
            access(1'($urandom), 2'($urandom), 0);
        end
        $display("test random timing done");
        xw_en = 1'b0;
        for (i = 0; i < 8; i++) begin
            cfg(i[0] ? 28'hfffffff : 28'h0, 8'h00);
            sel_strb = i[1];
            access(i[2], 2'(i % 3), 0);
        end
        $display("test count limits done");
        xw_en = 1'b1;
        for (i = 0; i < 6; i++) begin
            cfg(28'($urandom), (i == 3) ? 8'hff : 8'h01);
            rd_str = 6'h05;
            wr_str = 6'h05;
            sel_strb = i[1];
            access(i[0], 2'(i % 3), (i < 4) ? 1 : 2);
        end
        $display("test extended wait done");
        xw_en = 1'b0;
        access(1'b0, 2'h1, 1);
        access(1'b1, 2'h2, 1);
        $display("test wait ignored done");
        print_verdict();
    end
endmodule

`default_nettype wire
